// File: tpp_fifo.sv
// fifo: parameterised flip-flop buffer with valid/ready on both sides
`timescale 1ns/1ps
module tpp_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// File: tpp_pkg.sv
// package: constants and types for the test pin sharing and probe block
package tpp_pkg;
	// boundary-scan controller states, standard 4-bit codes
	typedef enum logic [3:0] {
		TPP_EXIT2_DR  = 4'h0,
		TPP_EXIT1_DR  = 4'h1,
		TPP_SHIFT_DR  = 4'h2,
		TPP_PAUSE_DR  = 4'h3,
		TPP_SEL_IR    = 4'h4,
		TPP_UPD_DR    = 4'h5,
		TPP_CAP_DR    = 4'h6,
		TPP_SEL_DR    = 4'h7,
		TPP_EXIT2_IR  = 4'h8,
		TPP_EXIT1_IR  = 4'h9,
		TPP_SHIFT_IR  = 4'ha,
		TPP_PAUSE_IR  = 4'hb,
		TPP_IDLE      = 4'hc,
		TPP_UPD_IR    = 4'hd,
		TPP_CAP_IR    = 4'he,
		TPP_LOGIC_RST = 4'hf
	} tpp_tap_t;

	localparam int          TPP_IR_W         = 4;
	localparam logic [3:0]  TPP_IR_BYPASS    = 4'hf;
	localparam logic [3:0]  TPP_IR_PROBE     = 4'h1;
	localparam logic [3:0]  TPP_IR_PROBE_OFF = 4'h2;
	localparam logic [3:0]  TPP_IR_RESET     = 4'hf;
	localparam logic [1:0]  TPP_IR_CAPTURE   = 2'h1;
	localparam int          TPP_RELEASE_TCKS = 5;
	localparam int          TPP_SEL_W        = 4;
	localparam int          TPP_FIFO_DEPTH   = 16;
endpackage

// File: tpp_scan_tester.sv
// scan tester model: drives the shared test pins and samples the serial output
`timescale 1ns/1ps
module tpp_scan_tester (
	output logic     tms,
	output logic     tck,
	output logic     tdi,
	input wire logic tdo
);
	// tms idles high as if pulled up; tck stands low outside frames
	initial begin
		tms = 1'b1;
		tck = 1'b0;
		tdi = 1'b0;
	end
	// one 400 ns test clock; tdo is taken just before the rise, 200 ns after the fall
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#20;
		o = tdo;
		tck = 1'b1;
		#200;
		tck = 1'b0;
		#180;
	endtask
	task automatic claim();
		logic o;
		tms = 1'b0;
		#400;
		step(1'b0, 1'b0, o);
	endtask
	task automatic hold_high(input int n);
		logic o;
		for (int i = 0; i < n; i++) step(1'b1, 1'b0, o);
	endtask
	// idle to idle: select, capture, four shifts lsb first, update
	task automatic scan(input logic ir, input logic [3:0] d, output logic [3:0] q);
		logic o;
		step(1'b1, 1'b0, o);
		if (ir) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < 4; i++) step(i == 3, d[i], q[i]);
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

// File: tpp_test_port.sv
// top: shared test pin ownership, scan controller and probe routing
//
// Notes on behaviour
// R1 - In flexible mode a low TMS hands the shared TCK, TDI and TDO pins to the test logic.
// R2 - Once in test use the shared pins stay there until the scan controller is in logic reset.
// R3 - Five TCK rising edges with TMS high bring the controller to logic reset from any state.
// R4 - In dedicated mode TMS is the plain mode-select input and TCK, TDI, TDO are never user I/O.
// R5 - TDI feeds both the scan registers and probe selection, and TDO returns scan data.
// R6 - TCK clocks the probe and scan logic, and in flexible mode returns to user I/O at logic reset.
// R7 - Probe A carries the live value of any selected internal node, alongside probe B.
// R8 - Each probe pin serves as ordinary user I/O whenever probing is not active.
// R9 - A permanent probe disable, once set, stops any node ever reaching either probe pin.
// R10 - The dedicated/flexible choice is a static strap caught at startup, flexible when unset.
`timescale 1ns/1ps
module tpp_test_port
	import tpp_pkg::*;
#(
	parameter int NODES = 16,
	parameter int DEPTH = TPP_FIFO_DEPTH
) (
	input  wire logic             CLK,
	input  wire logic             RESET,
	input  wire logic             DEDICATED_STRAP,
	input  wire logic             PROBE_FUSE_BLOWN,
	input  wire logic             TMS,
	input  wire logic             TCK_IN,
	input  wire logic             TDI_IN,
	output logic                  TDO_OUT,
	output logic                  TDO_OE,
	input  wire logic [NODES-1:0] NODE_VALUES,
	input  wire logic             USER_TCK_OUT,
	input  wire logic             USER_TCK_OE,
	input  wire logic             USER_TDI_OUT,
	input  wire logic             USER_TDI_OE,
	input  wire logic             USER_TDO_OUT,
	input  wire logic             USER_TDO_OE,
	output logic                  USER_TCK_IN,
	output logic                  USER_TDI_IN,
	input  wire logic             USER_PRA_OUT,
	input  wire logic             USER_PRA_OE,
	input  wire logic             USER_PRB_OUT,
	input  wire logic             USER_PRB_OE,
	output logic                  TCK_OUT,
	output logic                  TCK_OE,
	output logic                  TDI_OUT,
	output logic                  TDI_OE,
	output logic                  PROBE_OUT_A,
	output logic                  PROBE_OE_A,
	output logic                  PROBE_OUT_B,
	output logic                  PROBE_OE_B,
	output logic                  TEST_OWNS_PINS,
	output logic                  PROBE_LOCKED,
	output logic                  DEDICATED_MODE
);
	// pin synchronisers: first stage read only by the second
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	// reset to idle pin levels (tms high, tck, tdi, fuse low): no false tck edge, no false lock
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			meta_q <= 4'h8;
			sync_q <= 4'h8;
		end else begin
			meta_q <= {TMS, TCK_IN, TDI_IN, PROBE_FUSE_BLOWN};
			sync_q <= meta_q;
		end
	end
	wire tms_s  = sync_q[3];
	wire tck_s  = sync_q[2];
	wire tdi_s  = sync_q[1];
	wire fuse_s = sync_q[0];

	// strap caught once after reset release; never follows later changes
	logic strap_meta_q;
	logic strap_sync_q;
	logic strap_done_q;
	logic dedicated_q;
	logic [1:0] strap_wait_q;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
			strap_done_q <= 1'b0;
			dedicated_q  <= 1'b0;
			strap_wait_q <= 2'h0;
		end else begin
			strap_meta_q <= DEDICATED_STRAP;
			strap_sync_q <= strap_meta_q;
			strap_wait_q <= {strap_wait_q[0], 1'b1};
			// wait until the strap has passed both sync stages before catching it
			if (strap_wait_q[1] && !strap_done_q) begin
				dedicated_q  <= strap_sync_q; // R10
				strap_done_q <= 1'b1;
			end
		end
	end

	// tck edges found by the system clock
	logic tck_prev_q;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tck_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= tck_s;
		end
	end
	wire tck_rise = tck_s && !tck_prev_q; // R6
	wire tck_fall = !tck_s && tck_prev_q;

	// ownership: flexible mode claims on low TMS, holds until logic reset
	logic own_q;
	tpp_tap_t tap_q;
	tpp_tap_t tap_d;
	wire in_reset = (tap_q == TPP_LOGIC_RST);
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			own_q <= 1'b0;
		end else if (!tms_s) begin
			own_q <= 1'b1; // R1
		end else if (in_reset) begin
			own_q <= 1'b0; // R2
		end
	end
	// in dedicated mode the controller listens always; in flexible only when owned or while TMS is low
	wire owned = dedicated_q || own_q; // R4
	wire step  = tck_rise && (owned || !tms_s);

	always_comb begin
		tap_d = tap_q;
		unique case (tap_q)
			TPP_LOGIC_RST: tap_d = tms_s ? TPP_LOGIC_RST : TPP_IDLE;
			TPP_IDLE:      tap_d = tms_s ? TPP_SEL_DR : TPP_IDLE;
			TPP_SEL_DR:    tap_d = tms_s ? TPP_SEL_IR : TPP_CAP_DR;
			TPP_CAP_DR:    tap_d = tms_s ? TPP_EXIT1_DR : TPP_SHIFT_DR;
			TPP_SHIFT_DR:  tap_d = tms_s ? TPP_EXIT1_DR : TPP_SHIFT_DR;
			TPP_EXIT1_DR:  tap_d = tms_s ? TPP_UPD_DR : TPP_PAUSE_DR;
			TPP_PAUSE_DR:  tap_d = tms_s ? TPP_EXIT2_DR : TPP_PAUSE_DR;
			TPP_EXIT2_DR:  tap_d = tms_s ? TPP_UPD_DR : TPP_SHIFT_DR;
			TPP_UPD_DR:    tap_d = tms_s ? TPP_SEL_DR : TPP_IDLE;
			TPP_SEL_IR:    tap_d = tms_s ? TPP_LOGIC_RST : TPP_CAP_IR;
			TPP_CAP_IR:    tap_d = tms_s ? TPP_EXIT1_IR : TPP_SHIFT_IR;
			TPP_SHIFT_IR:  tap_d = tms_s ? TPP_EXIT1_IR : TPP_SHIFT_IR;
			TPP_EXIT1_IR:  tap_d = tms_s ? TPP_UPD_IR : TPP_PAUSE_IR;
			TPP_PAUSE_IR:  tap_d = tms_s ? TPP_EXIT2_IR : TPP_PAUSE_IR;
			TPP_EXIT2_IR:  tap_d = tms_s ? TPP_UPD_IR : TPP_SHIFT_IR;
			TPP_UPD_IR:    tap_d = tms_s ? TPP_SEL_DR : TPP_IDLE;
		endcase
	end

	// scan registers
	logic [TPP_IR_W-1:0]  ir_sh_q;
	logic [TPP_IR_W-1:0]  ir_q;
	logic                 byp_q;
	logic [TPP_SEL_W-1:0] sel_sh_q;
	logic [TPP_SEL_W-1:0] sel_q;
	logic                 probe_en_q;
	logic                 lock_q;
	wire sel_ir_probe = (ir_q == TPP_IR_PROBE);
	wire sel_ir_off   = (ir_q == TPP_IR_PROBE_OFF);
	wire shift_ir     = (tap_q == TPP_SHIFT_IR);
	wire shift_dr     = (tap_q == TPP_SHIFT_DR);
	wire dr_tail      = sel_ir_probe ? sel_sh_q[0] : byp_q;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tap_q <= TPP_LOGIC_RST;
		end else if (step) begin
			tap_q <= tap_d; // R3
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ir_sh_q  <= TPP_IR_RESET;
			ir_q     <= TPP_IR_RESET;
			byp_q    <= 1'b0;
			sel_sh_q <= '0;
		end else if (step) begin
			if (tap_q == TPP_CAP_IR) begin
				ir_sh_q <= TPP_IR_W'(TPP_IR_CAPTURE);
			end else if (shift_ir) begin
				ir_sh_q <= {tdi_s, ir_sh_q[TPP_IR_W-1:1]}; // R5
			end
			if (tap_q == TPP_UPD_IR) begin
				ir_q <= ir_sh_q;
			end else if (tap_q == TPP_LOGIC_RST) begin
				ir_q <= TPP_IR_RESET;
			end
			if (tap_q == TPP_CAP_DR) begin
				byp_q    <= 1'b0;
				sel_sh_q <= sel_q;
			end else if (shift_dr) begin
				byp_q    <= tdi_s; // R5
				sel_sh_q <= {tdi_s, sel_sh_q[TPP_SEL_W-1:1]}; // R5
			end
		end
	end

	// probe select and enable; lock is sticky until power-on reset
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sel_q      <= '0;
			probe_en_q <= 1'b0;
			lock_q     <= 1'b0;
		end else begin
			if (fuse_s || (step && tap_q == TPP_UPD_DR && sel_ir_off)) begin
				lock_q <= 1'b1; // R9
			end
			if (step && tap_q == TPP_UPD_DR && sel_ir_probe) begin
				sel_q      <= sel_sh_q;
				probe_en_q <= 1'b1;
			end else if (tap_q == TPP_LOGIC_RST) begin
				// released pins bring no further tck step, so drop probing on arrival
				probe_en_q <= 1'b0; // R8
			end
		end
	end

	// tdo changes on falling tck while shifting
	logic tdo_q;
	logic tdo_oe_q;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tdo_q    <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else if (tck_fall) begin
			tdo_q    <= shift_ir ? ir_sh_q[0] : dr_tail; // R5
			tdo_oe_q <= shift_ir || shift_dr;
		end
	end

	// the probed node values pass through a fifo that is drained every cycle, so sampling never stalls
	logic [1:0] smp_q;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic [1:0] fifo_out_data;
	logic [1:0] probe_q;
	wire  [TPP_SEL_W-1:0] sel_b = sel_q + 1'b1;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			smp_q <= 2'h0;
		end else if (fifo_in_ready) begin
			smp_q <= {NODE_VALUES[sel_b], NODE_VALUES[sel_q]}; // R7
		end
	end
	tpp_fifo #(.WIDTH(2), .DEPTH(DEPTH)) u_fifo (
		.clk       (CLK),
		.reset     (RESET),
		.in_valid  (1'b1),
		.in_ready  (fifo_in_ready),
		.in_data   (smp_q),
		.out_valid (fifo_out_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out_data)
	);
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			probe_q <= 2'h0;
		end else if (fifo_out_valid) begin
			probe_q <= fifo_out_data;
		end
	end

	wire probing = probe_en_q && !lock_q; // R9
	wire pins_test = owned; // R2
	assign PROBE_OUT_A    = probing ? probe_q[0] : USER_PRA_OUT; // R7
	assign PROBE_OE_A     = probing ? 1'b1 : USER_PRA_OE; // R8
	assign PROBE_OUT_B    = probing ? probe_q[1] : USER_PRB_OUT;
	assign PROBE_OE_B     = probing ? 1'b1 : USER_PRB_OE; // R8
	assign TDO_OUT        = pins_test ? tdo_q : USER_TDO_OUT;
	assign TDO_OE         = pins_test ? tdo_oe_q : USER_TDO_OE; // R4
	assign TCK_OUT        = USER_TCK_OUT;
	assign TCK_OE         = pins_test ? 1'b0 : USER_TCK_OE; // R6
	assign TDI_OUT        = USER_TDI_OUT;
	assign TDI_OE         = pins_test ? 1'b0 : USER_TDI_OE;
	assign USER_TCK_IN    = pins_test ? 1'b0 : tck_s;
	assign USER_TDI_IN    = pins_test ? 1'b0 : tdi_s;
	assign TEST_OWNS_PINS = pins_test;
	assign PROBE_LOCKED   = lock_q;
	assign DEDICATED_MODE = dedicated_q;
endmodule

// File: tpp_test_port_checker.sv
// checker: pin ownership and probe properties at the top ports
`timescale 1ns/1ps
module tpp_test_port_checker (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic TMS,
	input wire logic PROBE_FUSE_BLOWN,
	input wire logic USER_TCK_OE,
	input wire logic USER_PRA_OUT,
	input wire logic USER_PRA_OE,
	input wire logic TCK_OE,
	input wire logic TDI_OE,
	input wire logic PROBE_OUT_A,
	input wire logic PROBE_OE_A,
	input wire logic TEST_OWNS_PINS,
	input wire logic PROBE_LOCKED,
	input wire logic DEDICATED_MODE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	a_claim_pins: assert property (!DEDICATED_MODE && $fell(TMS) |-> ##[1:4] TEST_OWNS_PINS)
		else $error("pins not claimed after tms low");
	// one test clock early would release within 15 cycles of tms rising
	a_release_late: assert property ($fell(TEST_OWNS_PINS) |-> $past(TMS, 15) && TMS)
		else $error("pins released too early");
	a_owned_quiet: assert property (TEST_OWNS_PINS && $past(TEST_OWNS_PINS) |-> !TCK_OE && !TDI_OE)
		else $error("user drives a pin held by test");
	a_user_pins: assert property (!TEST_OWNS_PINS && !$past(TEST_OWNS_PINS) && !DEDICATED_MODE
		|-> TCK_OE == USER_TCK_OE)
		else $error("released pin not under user control");
	a_dedicated_own: assert property (DEDICATED_MODE && $past(DEDICATED_MODE) |-> TEST_OWNS_PINS)
		else $error("dedicated pins not test owned");
	a_mode_static: assert property (DEDICATED_MODE |=> DEDICATED_MODE)
		else $error("mode changed after startup");
	a_lock_sticky: assert property (PROBE_LOCKED |=> PROBE_LOCKED)
		else $error("probe lock cleared");
	a_fuse_locks: assert property (PROBE_FUSE_BLOWN |-> ##[1:4] PROBE_LOCKED)
		else $error("fuse did not lock probes");
	a_locked_user: assert property (PROBE_LOCKED [*6] |->
		PROBE_OE_A == USER_PRA_OE && PROBE_OUT_A == USER_PRA_OUT)
		else $error("locked probe pin not user owned");
endmodule
bind tpp_test_port tpp_test_port_checker tpp_test_port_checker_inst (
	.CLK(CLK), .RESET(RESET), .TMS(TMS), .PROBE_FUSE_BLOWN(PROBE_FUSE_BLOWN),
	.USER_TCK_OE(USER_TCK_OE), .USER_PRA_OUT(USER_PRA_OUT), .USER_PRA_OE(USER_PRA_OE),
	.TCK_OE(TCK_OE), .TDI_OE(TDI_OE), .PROBE_OUT_A(PROBE_OUT_A), .PROBE_OE_A(PROBE_OE_A),
	.TEST_OWNS_PINS(TEST_OWNS_PINS), .PROBE_LOCKED(PROBE_LOCKED),
	.DEDICATED_MODE(DEDICATED_MODE)
);

// File: tpp_test_port_test.sv
// testbench: pin ownership, scan access and probe routing
`timescale 1ns/1ps
module tpp_test_port_test import tpp_pkg::*;;
	logic        clk = 0, reset = 1, strap = 0, fuse = 0;
	logic [15:0] nodes = 16'h0;
	logic [9:0]  u = 10'h0;
	logic [3:0]  q;
	logic        tdo, tdo_oe, uti, udi, tck_o, tck_oe, tdi_o, tdi_oe, t_tms, t_tck, t_tdi;
	logic        pa, poa, pb, pob, owns, locked, ded;
	int          err_count = 0, checks = 0, cycles = 0;
	// shared pins resolve from both drivers; a released tdo shows the inverse
	wire         tck_pin = tck_oe ? tck_o : t_tck;
	wire         tdi_pin = tdi_oe ? tdi_o : t_tdi;
	wire         tdo_pin = tdo_oe ? tdo : ~tdo;
	tpp_test_port tpp_test_port_inst (
		.CLK(clk), .RESET(reset), .DEDICATED_STRAP(strap), .PROBE_FUSE_BLOWN(fuse),
		.TMS(t_tms), .TCK_IN(tck_pin), .TDI_IN(tdi_pin), .TDO_OUT(tdo), .TDO_OE(tdo_oe),
		.NODE_VALUES(nodes), .USER_TCK_OUT(u[0]), .USER_TCK_OE(u[1]), .USER_TDI_OUT(u[2]),
		.USER_TDI_OE(u[3]), .USER_TDO_OUT(u[4]), .USER_TDO_OE(u[5]), .USER_TCK_IN(uti),
		.USER_TDI_IN(udi), .USER_PRA_OUT(u[6]), .USER_PRA_OE(u[7]), .USER_PRB_OUT(u[8]),
		.USER_PRB_OE(u[9]), .TCK_OUT(tck_o), .TCK_OE(tck_oe), .TDI_OUT(tdi_o),
		.TDI_OE(tdi_oe), .PROBE_OUT_A(pa), .PROBE_OE_A(poa), .PROBE_OUT_B(pb),
		.PROBE_OE_B(pob), .TEST_OWNS_PINS(owns), .PROBE_LOCKED(locked), .DEDICATED_MODE(ded)
	);
	tpp_scan_tester tpp_scan_tester_inst (.tms(t_tms), .tck(t_tck), .tdi(t_tdi), .tdo(tdo_pin));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (err_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		strap = s;
		reset = 1'b1;
		tick(8);
		reset = 1'b0;
		tick(6);
	endtask
	task automatic t_user(input logic [9:0] v, input logic [3:0] e_oe, input logic [3:0] e_d,
		input logic [3:0] e_in);
		u = v;
		tick(3);
		check({tck_oe, tdi_oe, tdo_oe, poa}, e_oe);
		check({tck_o, tdi_o, pa, pob}, e_d);
		check({2'h0, uti, udi}, e_in);
	endtask
	task automatic t_scan_probe();
		tpp_scan_tester_inst.claim();
		tick(1);
		check({owns, tck_oe, tdi_oe, uti}, 4'h8);
		tpp_scan_tester_inst.scan(1'b0, 4'ha, q);
		check(q, 4'h4);
		tpp_scan_tester_inst.scan(1'b1, TPP_IR_PROBE, q);
		check({2'h0, q[1:0]}, {2'h0, TPP_IR_CAPTURE});
		tpp_scan_tester_inst.scan(1'b0, 4'h5, q);
		nodes = 16'h0020;
		tick(6);
		check({pa, poa, pb, pob}, 4'hd);
		nodes = 16'h0040;
		tick(6);
		check({pa, poa, pb, pob}, 4'h7);
		// from idle the controller needs three high clocks to reach logic reset
		tpp_scan_tester_inst.hold_high(2);
		tick(4);
		check({3'h0, owns}, 4'h1);
		tpp_scan_tester_inst.hold_high(1);
		tick(4);
		check({owns, poa, pa, 1'b0}, 4'h2);
	endtask
	task automatic t_lock();
		tpp_scan_tester_inst.claim();
		tpp_scan_tester_inst.scan(1'b1, TPP_IR_PROBE_OFF, q);
		tpp_scan_tester_inst.scan(1'b0, 4'h0, q);
		tick(4);
		check({3'h0, locked}, 4'h1);
		tpp_scan_tester_inst.scan(1'b1, TPP_IR_PROBE, q);
		tpp_scan_tester_inst.scan(1'b0, 4'h5, q);
		nodes = 16'h0000;
		tick(6);
		check({poa, pa, 2'h0}, 4'h4);
		fuse = 1'b1;
		tick(4);
		fuse = 1'b0;
		tpp_scan_tester_inst.hold_high(5);
		tick(4);
		check({owns, locked, 2'h0}, 4'h4);
	endtask
	task automatic t_dedicated();
		do_reset(1'b1);
		check({ded, owns, tck_oe, tdi_oe}, 4'hc);
		tpp_scan_tester_inst.hold_high(5);
		tick(4);
		check({ded, owns, locked, 1'b0}, 4'hc);
	endtask
	initial begin
		do_reset(1'b0);
		check({3'h0, ded}, 4'h0);
		t_user(10'h00f, 4'hc, 4'hc, 4'h3);
		t_user(10'h2a5, 4'h3, 4'hd, 4'h0);
		t_user(10'h15a, 4'hc, 4'h2, 4'h0);
		t_scan_probe();
		t_lock();
		t_dedicated();
		stop_test();
	end
endmodule
